//--- fault_alarm_pkg.sv
// Shared constants and carriers for the fault alarm and monitor select block.
// Assumes a single 100 MHz clock and a 32-bit classic Wishbone register bus.
package fault_alarm_pkg;

  // Widths of flag groups and monitor converter fields
  localparam int DIG_W = 13;
  localparam int ANA_W = 11;
  localparam int MON_W = 12;
  localparam int SEL_W = 5;
  localparam int IRQ_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_DIG_FLAGS = 8'h00;
  localparam logic [7:0] OFS_ANA_FLAGS = 8'h04;
  localparam logic [7:0] OFS_ALARM_MASK = 8'h08;
  localparam logic [7:0] OFS_GENERAL_CONFIG_ONE = 8'h0c;
  localparam logic [7:0] OFS_MON_CONFIG = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // Digital flag positions and group masks
  localparam int DIG_OSC_STOP = 0;
  localparam int DIG_CAL_UNREFRESHED = 1;
  localparam int DIG_RESET_SEEN = 2;
  localparam int DIG_THREE_WIRE = 3;
  localparam int DIG_WATCHDOG = 4;
  localparam int DIG_SCLK_COUNT = 10;
  localparam logic [12:0] DIG_MAPPED = 13'h1ff9;
  localparam logic [12:0] DIG_MASKABLE = 13'h1ad1;
  localparam logic [12:0] DIG_RESET_VAL = 13'h0004;
  localparam logic [12:0] DIG_LIVE = 13'h0002;
  // Analog flags: all mapped, six maskable
  localparam int ANA_DCDC_POWER = 2;
  localparam logic [10:0] ANA_MASKABLE = 11'h07b;
  localparam logic [10:0] ANA_RESET_VAL = 11'h000;

  // Field positions
  localparam int GEN_SILENCE_BIT = 3;
  localparam int MASK_ANA_LSB = 16;
  localparam int ST_CODE_LSB = 12;
  localparam int ST_BUSY = 17;
  localparam int ST_DIG_SUM = 18;
  localparam int ST_ANA_SUM = 19;
  localparam int ST_WDT_SUM = 20;
  localparam int ST_SEL_RESV = 21;
  localparam int MIRROR_BIT = 31;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_CONV_DONE = 1;
  localparam int IRQ_CONV_IGNORED = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Monitor input select codes
  localparam logic [4:0] SEL_MAIN_TEMP = 5'h00;
  localparam logic [4:0] SEL_CONV_TEMP = 5'h01;
  localparam logic [4:0] SEL_REFERENCE_INPUT = 5'h03;
  localparam logic [4:0] SEL_INTERNAL_BANDGAP_REF = 5'h04;
  localparam logic [4:0] SEL_SENSE_POS = 5'h0d;
  localparam logic [4:0] SEL_SENSE_NEG = 5'h0e;
  localparam logic [4:0] SEL_INTERNAL_ANALOG_SUPPLY = 5'h14;
  localparam logic [4:0] SEL_REGULATOR_OUTPUT_SUPPLY = 5'h15;
  localparam logic [4:0] SEL_LOGIC_SUPPLY = 5'h16;

  // Completed conversion with the input it came from
  typedef struct packed {
    logic [SEL_W-1:0] code;
    logic [MON_W-1:0] data;
  } mon_result_t;

endpackage : fault_alarm_pkg

//--- sticky_flag_bank.sv
// Bank of sticky diagnostic flags with write-one update.
// Assumes fault inputs are synchronous levels and update is a one-cycle pulse.
module sticky_flag_bank #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '0,
  parameter logic [W-1:0] LIVE = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] fault,
  input wire logic [W-1:0] update,
  output logic [W-1:0] flags
);

  ////////////////////////////////////////////////////////////////////////////
  // One flop per flag; a fault present during an update keeps the flag set
  for (genvar i = 0; i < W; i++) begin : g_flag
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        flags[i] <= RESET_VAL[i];
      end else if (LIVE[i]) begin
        flags[i] <= fault[i]; // Self-clearing flag, no latch
      end else if (update[i]) begin
        flags[i] <= fault[i];
      end else begin
        flags[i] <= flags[i] | fault[i];
      end
    end

    if (!LIVE[i]) begin : g_chk
      chk_flag_reload: assert property (@(posedge clk) disable iff (sys_rst)
        update[i] |=> flags[i] == $past(fault[i]))
        else $error("sticky flag did not reload current fault");
      chk_flag_holds: assert property (@(posedge clk) disable iff (sys_rst)
        (flags[i] && !update[i]) |=> flags[i])
        else $error("sticky flag dropped without update");
    end
  end

endmodule : sticky_flag_bank

//--- monitor_conv_ctrl.sv
// Conversion sequencer for the 12-bit diagnostic monitor converter.
// Assumes the front end answers each start with one adcDone pulse.
module monitor_conv_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input wire logic [4:0] cmdSel,
  input wire logic adcDone,
  input wire logic [11:0] adcData,
  output logic adcStart,
  output logic [4:0] adcSel,
  output logic busy,
  output fault_alarm_pkg::mon_result_t result,
  output logic doneEvt,
  output logic ignoredEvt,
  output logic reservedSel
);

  typedef enum logic {IDLE, CONVERT} conv_state_t;
  conv_state_t state;
  logic selReserved;

  // Reserved select codes never start the converter
  always_comb begin
    selReserved = (cmdSel == 5'h02) || (cmdSel == 5'h05) || (cmdSel == 5'h06) ||
                  (cmdSel == 5'h0c) || (cmdSel[4:2] == 3'b100);
  end

  assign busy = (state == CONVERT);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: one start per accepted write, commands dropped while busy
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= IDLE;
      adcStart <= 1'b0;
      adcSel <= fault_alarm_pkg::SEL_MAIN_TEMP;
      result <= '0;
      doneEvt <= 1'b0;
      ignoredEvt <= 1'b0;
      reservedSel <= 1'b0;
    end else begin
      adcStart <= 1'b0;
      doneEvt <= 1'b0;
      ignoredEvt <= 1'b0;
      unique case (state)
        IDLE: begin
          if (cmdValid) begin
            reservedSel <= selReserved;
            if (!selReserved) begin
              adcSel <= cmdSel;
              adcStart <= 1'b1;
              state <= CONVERT;
            end
          end
        end
        CONVERT: begin
          ignoredEvt <= cmdValid;
          if (adcDone) begin
            result <= '{code: adcSel, data: adcData};
            doneEvt <= 1'b1;
            state <= IDLE;
          end
        end
      endcase
    end
  end

  chk_busy_ignores_cmd: assert property (@(posedge clk) disable iff (sys_rst)
    (busy && cmdValid && !adcDone) |=> $stable(adcSel) && $stable(result) && !adcStart)
    else $error("command taken while converter busy");
  chk_start_on_write: assert property (@(posedge clk) disable iff (sys_rst)
    (!busy && cmdValid && !selReserved) |=> adcStart && busy && adcSel == $past(cmdSel))
    else $error("accepted write did not start a conversion");

endmodule : monitor_conv_ctrl

//--- fault_alarm_top.sv
// Fault alarm aggregation, monitor select and register file.
// Assumes fault inputs are synchronous levels and a classic Wishbone master.
// Summary of operation
// - Alarm pin active-low open-drain, released when clear
// - Every readback carries inverted alarm pin level
// - Seven digital faults alarm unless masked
// - Four digital faults alarm with no mask
// - Calibration-unrefreshed and reset flags never alarm
// - All analog faults alarm, six maskable
// - Silence bit drops serial clock count error
// - Status gives digital, analog, watchdog summaries
// - 12-bit monitor converter, 5-bit input select
// - Select codes decode, reserved codes listed
// - Config write starts one conversion, result reported
// - Commands while busy ignored, old result kept
// - Sticky flags update on write of one
//
// The register offsets and the Wishbone slave port were decided locally.
module fault_alarm_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  input wire logic [12:0] digFault,
  input wire logic [10:0] anaFault,
  input wire logic alarmIn,
  output logic alarmOut,
  output logic alarmOe,
  output logic adcStart,
  output logic [4:0] adcSel,
  input wire logic adcDone,
  input wire logic [11:0] adcData,
  output logic irq
);

  localparam int DW = fault_alarm_pkg::DIG_W;
  localparam int AW = fault_alarm_pkg::ANA_W;

  logic req;
  logic acc;
  logic wrAcc;
  logic rdAcc;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] rdMux;
  logic [31:0] statusWord;
  logic [DW-1:0] digFlags;
  logic [AW-1:0] anaFlags;
  logic [DW-1:0] digUpdate;
  logic [AW-1:0] anaUpdate;
  logic [DW-1:0] digMask;
  logic [AW-1:0] anaMask;
  logic serial_diag_silence_enable;
  logic [DW-1:0] digPin;
  logic [AW-1:0] anaPin;
  logic next_alarm;
  logic alarmActive;
  logic mirror;
  logic digital_diag_summary;
  logic analog_diag_summary;
  logic watchdog_summary;
  logic [fault_alarm_pkg::IRQ_W-1:0] irqStatus;
  logic [fault_alarm_pkg::IRQ_W-1:0] irqMask;
  logic [fault_alarm_pkg::IRQ_W-1:0] irqEvt;
  logic [fault_alarm_pkg::IRQ_W-1:0] irqClr;
  logic monCmd;
  logic monBusy;
  logic monDone;
  logic monIgnored;
  logic monResv;
  fault_alarm_pkg::mon_result_t monResult;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone classic slave: ack one cycle after request, commit on ack
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wbAck <= 1'b0;
    end else begin
      wbAck <= wbCyc && wbStb && !wbAck;
    end
  end

  // Request cycle captures read data; the ack cycle is the commit edge
  assign req = wbCyc && wbStb && !wbAck;
  assign acc = wbCyc && wbStb && wbAck;
  assign wrAcc = acc && wbWe;
  assign rdAcc = acc && !wbWe;
  assign wmask = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};
  assign wval = wbDatI & wmask;

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostic flag banks; the reset flag powers up set
  assign digUpdate = (wrAcc && wbAdr == fault_alarm_pkg::OFS_DIG_FLAGS) ? wval[DW-1:0] : '0;
  assign anaUpdate = (wrAcc && wbAdr == fault_alarm_pkg::OFS_ANA_FLAGS) ? wval[AW-1:0] : '0;

  sticky_flag_bank #(
    .W(DW),
    .RESET_VAL(fault_alarm_pkg::DIG_RESET_VAL),
    .LIVE(fault_alarm_pkg::DIG_LIVE)
  ) u_dig_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .fault(digFault),
    .update(digUpdate),
    .flags(digFlags)
  );

  sticky_flag_bank #(
    .W(AW),
    .RESET_VAL(fault_alarm_pkg::ANA_RESET_VAL),
    .LIVE('0)
  ) u_ana_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .fault(anaFault),
    .update(anaUpdate),
    .flags(anaFlags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Alarm mask register; only maskable positions hold a bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      digMask <= '0;
      anaMask <= '0;
    end else if (wrAcc && wbAdr == fault_alarm_pkg::OFS_ALARM_MASK) begin
      digMask <= wval[DW-1:0] & fault_alarm_pkg::DIG_MASKABLE;
      anaMask <= wval[fault_alarm_pkg::MASK_ANA_LSB +: AW] & fault_alarm_pkg::ANA_MASKABLE;
    end
  end

  // General configuration: serial diagnostic silence
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serial_diag_silence_enable <= 1'b0;
    end else if (wrAcc && wbAdr == fault_alarm_pkg::OFS_GENERAL_CONFIG_ONE && wbSel[0]) begin
      serial_diag_silence_enable <= wbDatI[fault_alarm_pkg::GEN_SILENCE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin mapping: mask bit set keeps the source off the pin
  always_comb begin
    digPin = digFlags & fault_alarm_pkg::DIG_MAPPED & ~digMask;
    if (serial_diag_silence_enable) begin
      digPin[fault_alarm_pkg::DIG_SCLK_COUNT] = 1'b0;
    end
    anaPin = anaFlags & ~anaMask;
    next_alarm = (|digPin) || (|anaPin);
  end

  // Registered alarm, one cycle after a flag or mask change
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alarmActive <= 1'b0;
    end else begin
      alarmActive <= next_alarm;
    end
  end

  // Open drain: only ever pull low, never drive high
  assign alarmOut = 1'b0;
  assign alarmOe = alarmActive;

  // Mirror follows the shared wire, so another device's pull shows too
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mirror <= 1'b0;
    end else begin
      mirror <= !alarmIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Group summaries, taken from the sticky flags
  assign digital_diag_summary = |digFlags;
  assign analog_diag_summary = |anaFlags;
  assign watchdog_summary = digFlags[fault_alarm_pkg::DIG_WATCHDOG];

  ////////////////////////////////////////////////////////////////////////////
  // Monitor converter control
  assign monCmd = wrAcc && wbAdr == fault_alarm_pkg::OFS_MON_CONFIG && wbSel[0];

  monitor_conv_ctrl u_monitor (
    .clk(clk),
    .sys_rst(sys_rst),
    .cmdValid(monCmd),
    .cmdSel(wbDatI[4:0]),
    .adcDone(adcDone),
    .adcData(adcData),
    .adcStart(adcStart),
    .adcSel(adcSel),
    .busy(monBusy),
    .result(monResult),
    .doneEvt(monDone),
    .ignoredEvt(monIgnored),
    .reservedSel(monResv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: read clears only the bits that were returned
  assign irqEvt = {monIgnored, monDone, next_alarm && !alarmActive};
  assign irqClr = (rdAcc && wbAdr == fault_alarm_pkg::OFS_IRQ_STATUS) ?
                  wbDatO[fault_alarm_pkg::IRQ_W-1:0] : '0;

  // New events win over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqStatus <= '0;
    end else begin
      irqStatus <= irqEvt | (irqStatus & ~irqClr);
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqMask <= '0;
    end else if (wrAcc && wbAdr == fault_alarm_pkg::OFS_IRQ_MASK && wbSel[0]) begin
      irqMask <= wbDatI[fault_alarm_pkg::IRQ_W-1:0];
    end
  end

  // Level interrupt while any enabled status bit is set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word layout
  always_comb begin
    statusWord = '0;
    statusWord[fault_alarm_pkg::MON_W-1:0] = monResult.data;
    statusWord[fault_alarm_pkg::ST_CODE_LSB +: fault_alarm_pkg::SEL_W] = monResult.code;
    statusWord[fault_alarm_pkg::ST_BUSY] = monBusy;
    statusWord[fault_alarm_pkg::ST_DIG_SUM] = digital_diag_summary;
    statusWord[fault_alarm_pkg::ST_ANA_SUM] = analog_diag_summary;
    statusWord[fault_alarm_pkg::ST_WDT_SUM] = watchdog_summary;
    statusWord[fault_alarm_pkg::ST_SEL_RESV] = monResv;
  end

  // Read multiplexer; unmapped offsets read zero apart from the mirror
  always_comb begin
    rdMux = '0;
    unique case (wbAdr)
      fault_alarm_pkg::OFS_DIG_FLAGS: rdMux[DW-1:0] = digFlags;
      fault_alarm_pkg::OFS_ANA_FLAGS: rdMux[AW-1:0] = anaFlags;
      fault_alarm_pkg::OFS_ALARM_MASK: begin
        rdMux[DW-1:0] = digMask;
        rdMux[fault_alarm_pkg::MASK_ANA_LSB +: AW] = anaMask;
      end
      fault_alarm_pkg::OFS_GENERAL_CONFIG_ONE: begin
        rdMux[fault_alarm_pkg::GEN_SILENCE_BIT] = serial_diag_silence_enable;
      end
      fault_alarm_pkg::OFS_MON_CONFIG: rdMux[4:0] = adcSel;
      fault_alarm_pkg::OFS_STATUS: rdMux = statusWord;
      fault_alarm_pkg::OFS_IRQ_STATUS: rdMux[fault_alarm_pkg::IRQ_W-1:0] = irqStatus;
      fault_alarm_pkg::OFS_IRQ_MASK: rdMux[fault_alarm_pkg::IRQ_W-1:0] = irqMask;
      default: rdMux = '0;
    endcase
    rdMux[fault_alarm_pkg::MIRROR_BIT] = mirror;
  end

  // Read data captured in the request cycle, zero otherwise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wbDatO <= '0;
    end else if (req && !wbWe) begin
      wbDatO <= rdMux;
    end else begin
      wbDatO <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on alarm mapping and readback
  chk_alarm_pulls_low: assert property (@(posedge clk) disable iff (sys_rst)
    next_alarm |=> alarmOe && !alarmOut)
    else $error("mapped fault did not pull alarm low");

  chk_alarm_releases: assert property (@(posedge clk) disable iff (sys_rst)
    !next_alarm |=> !alarmOe)
    else $error("alarm held with no mapped fault");

  chk_unmaskable_digital: assert property (@(posedge clk) disable iff (sys_rst)
    digFault[fault_alarm_pkg::DIG_THREE_WIRE] |-> ##2 alarmOe)
    else $error("unmaskable digital fault missed the pin");

  chk_unmaskable_analog: assert property (@(posedge clk) disable iff (sys_rst)
    anaFault[fault_alarm_pkg::ANA_DCDC_POWER] |-> ##2 alarmOe)
    else $error("unmaskable analog fault missed the pin");

  // Only the two unmapped flags set: the wire must stay released
  chk_never_mapped: assert property (@(posedge clk) disable iff (sys_rst)
    (digFlags[12:3] == '0 && !digFlags[0] && anaFlags == '0) |=> !alarmOe)
    else $error("unmapped flag reached the pin");

  chk_masked_source: assert property (@(posedge clk) disable iff (sys_rst)
    (digMask[0] && digFlags[12:3] == '0 && anaFlags == '0) |=> !alarmOe)
    else $error("masked source reached the pin");

  chk_silence_sclk: assert property (@(posedge clk) disable iff (sys_rst)
    (serial_diag_silence_enable && digFlags[12:11] == '0 && digFlags[9:3] == '0 &&
     !digFlags[0] && anaFlags == '0) |=> !alarmOe)
    else $error("silenced clock count error reached the pin");

  chk_mirror_readback: assert property (@(posedge clk) disable iff (sys_rst)
    (wbAck && !wbWe) |-> wbDatO[fault_alarm_pkg::MIRROR_BIT] == !$past(alarmIn, 2))
    else $error("readback mirror disagrees with alarm pin");

  chk_watchdog_summary: assert property (@(posedge clk) disable iff (sys_rst)
    digFault[fault_alarm_pkg::DIG_WATCHDOG] |=> watchdog_summary && digital_diag_summary)
    else $error("watchdog fault not summarised");

endmodule : fault_alarm_top

//--- fault_alarm_far_side.sv
// Far side of the fault alarm block: shared wire and monitor front end.
// Assumes the wire has a pull-up and that one other device may pull it.
module fault_alarm_far_side (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic alarmOut,
  input wire logic alarmOe,
  input wire logic otherPull,
  input wire logic slow,
  input wire logic adcStart,
  input wire logic [4:0] adcSel,
  output logic alarmIn,
  output logic adcDone,
  output logic [11:0] adcData
);
  timeunit 1ns;
  timeprecision 1ps;
  int waitCount;
  real tempC;

  ////////////////////////////////////////////////////////////////////////
  // Pull-up wire, low while any party pulls
  assign alarmIn = !((alarmOe && !alarmOut) || otherPull);

  // One done pulse per start; data toggles outside the done cycle
  always_ff @(posedge clk) begin
    adcDone <= 1'b0;
    adcData <= ~adcData; // No stale value for the block to lean on
    if (sys_rst) begin
      waitCount <= 0;
      adcData <= 12'h000;
    end else if (adcStart) begin
      waitCount <= slow ? 20 : 2;
    end else if (waitCount == 1) begin
      adcDone <= 1'b1;
      adcData <= {adcSel, 7'h2b};
      waitCount <= 0;
    end else if (waitCount > 1) begin
      waitCount <= waitCount - 1;
    end
  end

  // Host scaling of a converter-die code, kept for inspection only
  always_ff @(posedge clk) begin
    if (adcDone && adcSel == 5'h01) tempC <= 436.0 - 0.11944 * adcData;
  end
endmodule : fault_alarm_far_side

//--- fault_alarm_and_monitor_select_bench.sv
// Self-checking bench for the fault alarm and monitor select block.
// Assumes fault_alarm_pkg, fault_alarm_top and fault_alarm_far_side.
module fault_alarm_and_monitor_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] CODES [17] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h0d, 5'h0e, 5'h14,
    5'h15, 5'h16, 5'h02, 5'h05, 5'h06, 5'h0c, 5'h10, 5'h11, 5'h12, 5'h13};
  logic clk, sys_rst, wbCyc, wbStb, wbWe, wbAck, alarmIn, alarmOut, alarmOe;
  logic adcStart, adcDone, irq, otherPull, slow;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI, wbDatO, q;
  logic [12:0] digFault;
  logic [10:0] anaFault;
  logic [4:0] adcSel;
  logic [11:0] adcData;
  int failCount = 0;
  int checkCount = 0;

  fault_alarm_top dut (.clk(clk), .sys_rst(sys_rst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbAck(wbAck), .digFault(digFault), .anaFault(anaFault), .alarmIn(alarmIn),
    .alarmOut(alarmOut), .alarmOe(alarmOe), .adcStart(adcStart), .adcSel(adcSel),
    .adcDone(adcDone), .adcData(adcData), .irq(irq));
  fault_alarm_far_side far (.clk(clk), .sys_rst(sys_rst), .alarmOut(alarmOut),
    .alarmOe(alarmOe), .otherPull(otherPull), .slow(slow), .adcStart(adcStart),
    .adcSel(adcSel), .alarmIn(alarmIn), .adcDone(adcDone), .adcData(adcData));

  ////////////////////////////////////////////////////////////////////////
  // Clock and shared helpers
  always #5 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Classic cycle; waits for ack, bounded at 20 cycles
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= 4'hf;
    wbDatI <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    chk("ack", 32'h1, {31'h0, wbAck});
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic wipe();
    digFault <= 13'h0;
    anaFault <= 11'h0;
    wr(fault_alarm_pkg::OFS_DIG_FLAGS, 32'h1fff);
    wr(fault_alarm_pkg::OFS_ANA_FLAGS, 32'h7ff);
    tick(3);
  endtask : wipe

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_reset();
    rd(fault_alarm_pkg::OFS_DIG_FLAGS);
    chk("reset flags", {19'h0, fault_alarm_pkg::DIG_RESET_VAL}, q);
    chk("pin idle", 32'h0, {30'h0, alarmOe, alarmOut});
    rd(8'h40);
    chk("unmapped", 32'h0, q);
    wr(fault_alarm_pkg::OFS_DIG_FLAGS, 32'h4);
    rd(fault_alarm_pkg::OFS_DIG_FLAGS);
    chk("flag update", 32'h0, q);
    $display("test reset done");
  endtask : test_reset

  // Every source alone, with all masks clear or all set
  task automatic test_sources(input logic m);
    logic e;
    wr(fault_alarm_pkg::OFS_ALARM_MASK, {32{m}});
    rd(fault_alarm_pkg::OFS_ALARM_MASK);
    chk("mask", {5'h0, fault_alarm_pkg::ANA_MASKABLE, 3'h0, fault_alarm_pkg::DIG_MASKABLE}
      & {32{m}}, q);
    for (int i = 0; i < 24; i++) begin
      e = i < 13 ? fault_alarm_pkg::DIG_MAPPED[i] && !(m && fault_alarm_pkg::DIG_MASKABLE[i])
        : !(m && fault_alarm_pkg::ANA_MASKABLE[i - 13]);
      digFault <= 13'h1 << i;
      anaFault <= i < 13 ? 11'h0 : 11'h1 << (i - 13);
      tick(3);
      chk("pin", {31'h0, e}, {31'h0, alarmOe});
      rd(fault_alarm_pkg::OFS_DIG_FLAGS);
      chk("mirror", {31'h0, e}, {31'h0, q[31]});
      wipe();
    end
    $display("test sources done");
  endtask : test_sources

  task automatic test_silence();
    wr(fault_alarm_pkg::OFS_GENERAL_CONFIG_ONE, 32'h8);
    digFault <= 13'h400;
    tick(3);
    chk("silenced", 32'h0, {31'h0, alarmOe});
    wr(fault_alarm_pkg::OFS_GENERAL_CONFIG_ONE, 32'h0);
    tick(3);
    chk("unsilenced", 32'h1, {31'h0, alarmOe});
    wipe();
    $display("test silence done");
  endtask : test_silence

  task automatic test_summary();
    digFault <= 13'h10;
    tick(3);
    wr(fault_alarm_pkg::OFS_DIG_FLAGS, 32'h10);
    rd(fault_alarm_pkg::OFS_DIG_FLAGS);
    chk("sticky held", 32'h10, q & 32'h1fff);
    rd(fault_alarm_pkg::OFS_STATUS);
    chk("digital sum", 32'h140000, q & 32'h1c0000);
    wipe();
    anaFault <= 11'h4;
    tick(3);
    rd(fault_alarm_pkg::OFS_STATUS);
    chk("analog sum", 32'h080000, q & 32'h1c0000);
    wipe();
    otherPull <= 1'b1;
    tick(3);
    rd(fault_alarm_pkg::OFS_STATUS);
    chk("wire mirror", 32'h80000000, q & 32'h80000000);
    otherPull <= 1'b0;
    $display("test summary done");
  endtask : test_summary

  // Slow conversion with a command while busy, then the nine listed and eight reserved codes
  task automatic test_monitor();
    logic [4:0] c;
    slow <= 1'b1;
    rd(fault_alarm_pkg::OFS_IRQ_STATUS);
    wr(fault_alarm_pkg::OFS_MON_CONFIG, 32'h01);
    wr(fault_alarm_pkg::OFS_MON_CONFIG, 32'h16);
    rd(fault_alarm_pkg::OFS_STATUS);
    chk("busy old", 32'h20000, q & 32'h3ffff);
    tick(30);
    rd(fault_alarm_pkg::OFS_STATUS);
    chk("result", {15'h0, 5'h01, 5'h01, 7'h2b}, q & 32'h3ffff);
    chk("die temp", 32'h1a0, int'(far.tempC));
    rd(fault_alarm_pkg::OFS_IRQ_STATUS);
    chk("ignored evt", 32'h6, q & 32'h6);
    slow <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      c = i < 9 ? CODES[i] : 5'h16;
      wr(fault_alarm_pkg::OFS_MON_CONFIG, {27'h0, CODES[i]});
      tick(6);
      rd(fault_alarm_pkg::OFS_STATUS);
      chk("select", {10'h0, i >= 9, 4'h0, c, c, 7'h2b}, q & 32'h23ffff);
    end
    $display("test monitor done");
  endtask : test_monitor

  task automatic test_irq();
    rd(fault_alarm_pkg::OFS_IRQ_STATUS);
    wr(fault_alarm_pkg::OFS_IRQ_MASK, 32'h2);
    wr(fault_alarm_pkg::OFS_MON_CONFIG, 32'h03);
    tick(8);
    chk("irq raised", 32'h1, {31'h0, irq});
    rd(fault_alarm_pkg::OFS_MON_CONFIG);
    chk("sel readback", 32'h3, q & 32'h1f);
    rd(fault_alarm_pkg::OFS_IRQ_STATUS);
    chk("irq status", 32'h2, q & 32'h7);
    tick(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(fault_alarm_pkg::OFS_IRQ_MASK, 32'h0);
    wr(fault_alarm_pkg::OFS_MON_CONFIG, 32'h04);
    tick(8);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("test irq done");
  endtask : test_irq

  ////////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog
  task automatic testDone();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : testDone

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {wbCyc, wbStb, wbWe, otherPull, slow} = 5'h0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatI = 32'h0;
    digFault = 13'h0;
    anaFault = 11'h0;
    tick(5);
    sys_rst <= 1'b0;
    test_reset();
    test_sources(1'b1);
    test_sources(1'b0);
    test_silence();
    test_summary();
    test_monitor();
    test_irq();
    testDone();
  end

  // Whole run needs about 1100 cycles
  initial begin
    #200000;
    failCount++;
    testDone();
  end
endmodule : fault_alarm_and_monitor_select_bench
